// File: dsp_opcode_decode_upper_test.sv
`timescale 1ns/10ps
`default_nettype none

module dsp_opcode_decode_upper_test;
  logic mclk;
  logic rst;
  wire logic fetch_valid;
  wire logic [15:0] fetch_word;
  wire logic cond_done;
  wire logic cond_taken;
  logic issue_valid;
  odu_pkg::odu_op_t issue_op;
  logic [7:0] operand_address_field;
  logic [2:0] aux_select_field;
  logic [3:0] shift_amount_field;
  logic [12:0] imm_field;
  logic [7:0] condition_select_field;
  logic [15:0] second_word;
  logic [1:0] issue_words;
  logic [2:0] issue_cycles;
  logic unknown_op;
  logic decode_busy;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] qw[$];
  odu_pkg::odu_op_t qo[$];

  odu_fetch_model fm (.mclk (mclk), .fetch_valid (fetch_valid), .fetch_word (fetch_word),
    .cond_done (cond_done), .cond_taken (cond_taken));
  odu_decode DUT (.mclk (mclk), .rst (rst), .fetch_valid (fetch_valid),
    .fetch_word (fetch_word), .cond_done (cond_done), .cond_taken (cond_taken),
    .issue_valid (issue_valid), .issue_op (issue_op),
    .operand_address_field (operand_address_field), .aux_select_field (aux_select_field),
    .shift_amount_field (shift_amount_field), .imm_field (imm_field),
    .condition_select_field (condition_select_field), .second_word (second_word),
    .issue_words (issue_words), .issue_cycles (issue_cycles), .unknown_op (unknown_op),
    .decode_busy (decode_busy));

  // clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_issue(input odu_pkg::odu_op_t op, input logic [2:0] c, input logic [1:0] w);
    chk("issue_valid", 16'h1, {15'h0, issue_valid});
    chk("issue_op", {9'h0, op}, {9'h0, issue_op});
    chk("issue_cycles", {13'h0, c}, {13'h0, issue_cycles});
    chk("issue_words", {14'h0, w}, {14'h0, issue_words});
  endtask

  task automatic add(input logic [15:0] w, input odu_pkg::odu_op_t o);
    qw.push_back(w);
    qo.push_back(o);
  endtask

  // words back to back, each issue judged the cycle after it is taken
  task automatic run_list();
    for (int i = 0; i <= qw.size(); i++)
    begin
      if (i < qw.size())
        fm.put(qw[i]);
      else
        fm.stop();
      #1;
      if (i > 0)
        chk_issue(qo[i-1], 3'h1, 2'h1);
    end
    qw.delete();
    qo.delete();
  endtask

  task automatic t_single();
    logic [3:0] an[7] = '{4'h2, 4'h3, 4'h5, 4'h9, 4'ha, 4'hc, 4'hd};
    logic [3:0] sn[7] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hb, 4'hd, 4'hf};
    for (int i = 0; i < 7; i++)
    begin
      add({12'hbe0, an[i]}, odu_pkg::odu_op_t'(7'h0c + 7'(i)));
      add({12'hbe4, sn[i]}, odu_pkg::odu_op_t'(7'h1f + 7'(i)));
    end
    add(16'h8b8d, odu_pkg::OP_AUX_POINTER);
    add(16'h8b42, odu_pkg::OP_AUX_MODIFY);
    add(16'h5412, odu_pkg::OP_MULTIPLY_OP);
    add(16'hc123, odu_pkg::OP_MULTIPLY_IMM);
    add(16'h5507, odu_pkg::OP_MULT_UNSIGNED);
    add(16'h5312, odu_pkg::OP_SQUARE_SUB);
    add(16'hbe3c, odu_pkg::OP_ACC_TO_STACK);
    add(16'h8a11, odu_pkg::OP_STACK_TO_MEMORY);
    add(16'hbb7f, odu_pkg::OP_REPEAT_IMM);
    add(16'h7c05, odu_pkg::OP_AUX_SUB_IMM);
    add(16'hbf11, odu_pkg::OP_PRODUCT_SHIFT);
    add(16'h8f44, odu_pkg::OP_STORE_STATUS1);
    add(16'hba0f, odu_pkg::OP_SUB_SHORT_IMM);
    add(16'h0a01, odu_pkg::OP_COND_SUBTRACT);
    add(16'h6d01, odu_pkg::OP_OR_MEM);
    add(16'ha001, odu_pkg::OP_ACC_NORMALIZE);
    add(16'h5001, odu_pkg::OP_MULT_ADD_PREV);
    add(16'h5102, odu_pkg::OP_MULT_SUB_PREV);
    add(16'h5203, odu_pkg::OP_SQUARE_ADD);
    add(16'hbe32, odu_pkg::OP_STACK_TO_ACC);
    add(16'h7604, odu_pkg::OP_MEMORY_TO_STACK);
    add(16'h0b05, odu_pkg::OP_REPEAT_MEM);
    add(16'h9506, odu_pkg::OP_STORE_ACC_LOW);
    add(16'h8d07, odu_pkg::OP_STORE_PROD_HIGH);
    add(16'h8c08, odu_pkg::OP_STORE_PROD_LOW);
    add(16'h8e09, odu_pkg::OP_STORE_STATUS0);
    add(16'h650a, odu_pkg::OP_SUB_HIGH);
    add(16'h640b, odu_pkg::OP_SUB_WITH_BORROW);
    add(16'h660c, odu_pkg::OP_SUB_NO_SIGN_EXT);
    add(16'h670d, odu_pkg::OP_SUB_TEMP_SHIFT);
    add(16'h6c0e, odu_pkg::OP_XOR_MEM);
    add(16'h680f, odu_pkg::OP_LOAD_HIGH_ROUND);
    run_list();
  endtask

  // odd entries wait a cycle for the operand word
  task automatic t_two_word();
    logic [15:0] w1[8] = '{16'ha211, 16'ha322, 16'hae33, 16'hbfa5, 16'hbfc3, 16'hbe82,
                           16'hbfd7, 16'hbe83};
    logic [2:0] cy[8] = '{3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2};
    odu_pkg::odu_op_t op[8] = '{odu_pkg::OP_MULT_ACCUM, odu_pkg::OP_MULT_ACCUM_MOVE,
      odu_pkg::OP_STORE_LONG_IMM, odu_pkg::OP_SUB_LONG_IMM, odu_pkg::OP_OR_LONG_IMM,
      odu_pkg::OP_OR_IMM_SHIFT16, odu_pkg::OP_XOR_LONG_IMM, odu_pkg::OP_XOR_IMM_SHIFT16};
    for (int i = 0; i < 8; i++)
    begin
      fm.put(w1[i]);
      if (i % 2 == 1)
      begin
        fm.stop();
        #1;
        chk("busy", 16'h1, {15'h0, decode_busy});
      end
      fm.put(16'h1234 + 16'(i));
      fm.stop();
      #1;
      chk_issue(op[i], cy[i], 2'h2);
      chk("second_word", 16'h1234 + 16'(i), second_word);
      chk("shift", {12'h0, (i == 3 || i == 4 || i == 6) ? w1[i][3:0] : 4'h0},
          {12'h0, shift_amount_field});
    end
  endtask

  task automatic t_return();
    fm.put(16'hef00);
    fm.stop();
    #1;
    chk_issue(odu_pkg::OP_SUBROUTINE_RETURN, 3'h4, 2'h1);
    fm.resolve(1'b1);
    fm.put(16'hec12);
    #1;
    chk("stray cond", 16'h0, {15'h0, issue_valid});
    fm.resolve(1'b0);
    fm.stop();
    #1;
    chk_issue(odu_pkg::OP_COND_RETURN, 3'h2, 2'h1);
    chk("condition", 16'h12, {8'h0, condition_select_field});
    fm.put(16'hed34);
    fm.put(16'h5512);
    fm.stop();
    #1;
    chk("cond wait", 16'h3, {14'h0, decode_busy, ~issue_valid});
    fm.resolve(1'b1);
    fm.stop();
    #1;
    chk_issue(odu_pkg::OP_COND_RETURN, 3'h4, 2'h1);
  endtask

  task automatic t_fields();
    fm.put(16'h9a33);
    fm.put(16'h8b00);
    #1;
    chk_issue(odu_pkg::OP_STORE_ACC_HIGH, 3'h1, 2'h1);
    chk("shift", 16'h2, {12'h0, shift_amount_field});
    chk("address", 16'h33, {8'h0, operand_address_field});
    fm.stop();
    #1;
    chk("unknown", 16'h2, {14'h0, unknown_op, issue_valid});
    fm.put(16'h8344);
    fm.put(16'h3a12);
    #1;
    chk_issue(odu_pkg::OP_STORE_AUX, 3'h1, 2'h1);
    chk("aux", 16'h3, {13'h0, aux_select_field});
    fm.put(16'hcabc);
    #1;
    chk_issue(odu_pkg::OP_SUB_MEM_SHIFT, 3'h1, 2'h1);
    chk("shift", 16'ha, {12'h0, shift_amount_field});
    fm.put(16'h8b8d);
    #1;
    chk("imm", 16'h0abc, {3'h0, imm_field});
    fm.stop();
    #1;
    chk("aux", 16'h5, {13'h0, aux_select_field});
  endtask

  // reset in the middle of a two-word wait
  task automatic t_reset();
    fm.put(16'ha211);
    fm.stop();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("busy", 16'h0, {15'h0, decode_busy});
    chk("op", {9'h0, odu_pkg::OP_NONE}, {9'h0, issue_op});
    chk("second_word", 16'h0, second_word);
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_single();
    t_two_word();
    t_return();
    t_fields();
    t_reset();
    t_single();
    results();
  end
endmodule

`default_nettype wire

// File: odu_decode.sv
`timescale 1ns/10ps
`default_nettype none

module odu_decode (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // fetch side
  input  wire logic             fetch_valid,
  input  wire logic [15:0]      fetch_word,
  // condition result from the datapath
  input  wire logic             cond_done,
  input  wire logic             cond_taken,
  // issue side
  output logic                  issue_valid,
  output odu_pkg::odu_op_t      issue_op,
  output logic [7:0]            operand_address_field,
  output logic [2:0]            aux_select_field,
  output logic [3:0]            shift_amount_field,
  output logic [12:0]           imm_field,
  output logic [7:0]            condition_select_field,
  output logic [15:0]           second_word,
  output logic [1:0]            issue_words,
  output logic [2:0]            issue_cycles,
  output logic                  unknown_op,
  output logic                  decode_busy
);

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  odu_pkg::odu_op_t t_op;
  logic [1:0]       t_words;
  logic [2:0]       t_cycles;
  logic             t_cond;
  logic             t_valid;

  odu_table u_table (
    .word    (fetch_word),
    .op      (t_op),
    .words   (t_words),
    .cycles  (t_cycles),
    .is_cond (t_cond),
    .valid   (t_valid)
  );

  // ----------------------------------------------------------------
  // state and held fields
  // ----------------------------------------------------------------
  odu_pkg::odu_state_t state_r, state_nxt;
  odu_pkg::odu_op_t    op_r, op_nxt;
  logic [15:0]         first_r, first_nxt;
  logic [15:0]         second_r, second_nxt;
  logic [1:0]          words_r, words_nxt;
  logic [2:0]          cycles_r, cycles_nxt;
  logic                issue_r, issue_nxt;
  logic                unk_r, unk_nxt;
  logic [3:0]          shift_r, shift_nxt;
  logic [2:0]          aux_r, aux_nxt;
  logic                busy_r, busy_nxt;

  // next-state: one-word unconditional forms issue at once, others hold
  always_comb
  begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    first_nxt  = first_r;
    second_nxt = second_r;
    words_nxt  = words_r;
    cycles_nxt = cycles_r;
    issue_nxt  = 1'b0;
    unk_nxt    = 1'b0;
    shift_nxt  = shift_r;
    aux_nxt    = aux_r;
    case (state_r)
      odu_pkg::ST_IDLE:
      begin
        if (fetch_valid)
        begin
          op_nxt     = t_op;
          first_nxt  = fetch_word;
          second_nxt = 16'h0000;
          words_nxt  = t_words;
          cycles_nxt = t_cycles;
          unk_nxt    = ~t_valid;
          aux_nxt    = fetch_word[2:0];
          // fields picked here so each output is a bare flip-flop
          case (t_op)
            odu_pkg::OP_SUB_MEM_SHIFT:
              shift_nxt = fetch_word[11:8];
            odu_pkg::OP_STORE_ACC_HIGH,
            odu_pkg::OP_STORE_ACC_LOW:
              shift_nxt = {1'b0, fetch_word[10:8]};
            odu_pkg::OP_SUB_LONG_IMM,
            odu_pkg::OP_OR_LONG_IMM,
            odu_pkg::OP_XOR_LONG_IMM:
              shift_nxt = fetch_word[3:0];
            odu_pkg::OP_STORE_AUX:
            begin
              shift_nxt = 4'h0;
              aux_nxt   = fetch_word[odu_pkg::SEL_MSB:8];
            end
            default:
              shift_nxt = 4'h0;
          endcase
          if (t_valid && t_words == odu_pkg::WORDS_TWO)
            state_nxt = odu_pkg::ST_WAIT2;
          else if (t_cond)
            state_nxt = odu_pkg::ST_COND;
          else
            issue_nxt = t_valid;
        end
      end
      odu_pkg::ST_WAIT2:
      begin
        // the operand word is captured before anything leaves
        if (fetch_valid)
        begin
          second_nxt = fetch_word;
          issue_nxt  = 1'b1;
          state_nxt  = odu_pkg::ST_IDLE;
        end
      end
      odu_pkg::ST_COND:
      begin
        // count is unknown until the datapath resolves the condition
        if (cond_done)
        begin
          cycles_nxt = cond_taken ? odu_pkg::CYC_FOUR : odu_pkg::CYC_TWO;
          issue_nxt  = 1'b1;
          state_nxt  = odu_pkg::ST_IDLE;
        end
      end
      default:
        state_nxt = odu_pkg::ST_IDLE;
    endcase
    // busy registered with the state so the pin needs no inverter
    busy_nxt = (state_nxt != odu_pkg::ST_IDLE);
  end

  // register stage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r  <= odu_pkg::ST_IDLE;
      op_r     <= odu_pkg::OP_NONE;
      first_r  <= 16'h0000;
      second_r <= 16'h0000;
      words_r  <= 2'h0;
      cycles_r <= 3'h0;
      issue_r  <= 1'b0;
      unk_r    <= 1'b0;
      shift_r  <= 4'h0;
      aux_r    <= 3'h0;
      busy_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      first_r  <= first_nxt;
      second_r <= second_nxt;
      words_r  <= words_nxt;
      cycles_r <= cycles_nxt;
      issue_r  <= issue_nxt;
      unk_r    <= unk_nxt;
      shift_r  <= shift_nxt;
      aux_r    <= aux_nxt;
      busy_r   <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all flip-flops or slices of them
  // ----------------------------------------------------------------
  assign issue_valid            = issue_r;
  assign issue_op               = op_r;
  assign operand_address_field  = first_r[odu_pkg::ADDR_MSB:0];
  assign aux_select_field       = aux_r;
  assign shift_amount_field     = shift_r;
  assign imm_field              = first_r[12:0];
  assign condition_select_field = first_r[7:0];
  assign second_word            = second_r;
  assign issue_words            = words_r;
  assign issue_cycles           = cycles_r;
  assign unknown_op             = unk_r;
  assign decode_busy            = busy_r;

endmodule

`default_nettype wire

// File: odu_decode_properties.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// decode checker, ports only
// ----------------------------------------------------------------
module odu_checker (
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // fetch side
  input wire logic             fetch_valid,
  input wire logic [15:0]      fetch_word,
  input wire logic             cond_done,
  input wire logic             cond_taken,
  // issue side
  input wire logic             issue_valid,
  input wire odu_pkg::odu_op_t issue_op,
  input wire logic [7:0]       operand_address_field,
  input wire logic [2:0]       aux_select_field,
  input wire logic [3:0]       shift_amount_field,
  input wire logic [12:0]      imm_field,
  input wire logic [7:0]       condition_select_field,
  input wire logic [15:0]      second_word,
  input wire logic [1:0]       issue_words,
  input wire logic [2:0]       issue_cycles,
  input wire logic             unknown_op,
  input wire logic             decode_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // first word taken while idle
  sequence s_take(logic [7:0] hi);
    fetch_valid && !decode_busy && fetch_word[15:8] == hi;
  endsequence
  // conditional return opened, not the plain return
  sequence s_cond_open;
    fetch_valid && !decode_busy && fetch_word[15:10] == 6'h3b && fetch_word != 16'hef00;
  endsequence

  property p_mult_accum;
    s_take(8'ha2) ##1 fetch_valid |=> issue_valid && issue_op == odu_pkg::OP_MULT_ACCUM
      && issue_cycles == 3'h3 && issue_words == 2'h2 && second_word == $past(fetch_word);
  endproperty
  a_mult_accum: assert property (p_mult_accum) else $error("two-word issue wrong");

  // waiting for an operand never issues
  property p_hold;
    decode_busy && !fetch_valid && !cond_done |=> decode_busy && !issue_valid
      && $stable(second_word);
  endproperty
  a_hold: assert property (p_hold) else $error("issue while waiting");

  property p_unsigned;
    s_take(8'h55) |=> issue_valid && issue_op == odu_pkg::OP_MULT_UNSIGNED
      && issue_cycles == 3'h1 && operand_address_field == $past(fetch_word[7:0]);
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("unsigned multiply wrong");

  property p_return;
    fetch_valid && !decode_busy && fetch_word == 16'hef00 |=> issue_valid
      && issue_op == odu_pkg::OP_SUBROUTINE_RETURN && issue_cycles == 3'h4;
  endproperty
  a_return: assert property (p_return) else $error("return wrong");

  property p_cond_end;
    s_cond_open ##1 cond_done |=> issue_valid && issue_op == odu_pkg::OP_COND_RETURN
      && issue_cycles == ($past(cond_taken) ? 3'h4 : 3'h2)
      && condition_select_field == $past(fetch_word[7:0], 2);
  endproperty
  a_cond_end: assert property (p_cond_end) else $error("conditional count wrong");

  property p_store_high;
    fetch_valid && !decode_busy && fetch_word[15:11] == 5'h13 |=>
      issue_op == odu_pkg::OP_STORE_ACC_HIGH
      && shift_amount_field == {1'b0, $past(fetch_word[10:8])};
  endproperty
  a_store_high: assert property (p_store_high) else $error("store shift wrong");

  property p_unknown;
    fetch_valid && !decode_busy && fetch_word == 16'h8b00 |=> unknown_op && !issue_valid;
  endproperty
  a_unknown: assert property (p_unknown) else $error("no-op not refused");

  // odd set codes other than 9 are all one-cycle set operations
  property p_set;
    fetch_valid && !decode_busy && fetch_word[15:4] == 12'hbe4 && fetch_word[0]
      && fetch_word[3:0] != 4'h9 |=> issue_valid && !unknown_op && issue_cycles == 3'h1;
  endproperty
  a_set: assert property (p_set) else $error("set operation missed");

  property p_idle;
    !fetch_valid && !decode_busy |=> !issue_valid && !unknown_op && $stable(issue_op)
      && $stable(issue_cycles);
  endproperty
  a_idle: assert property (p_idle) else $error("output moved without a word");
endmodule

bind odu_decode odu_checker u_chk (.mclk, .rst, .fetch_valid, .fetch_word, .cond_done,
  .cond_taken, .issue_valid, .issue_op, .operand_address_field, .aux_select_field,
  .shift_amount_field, .imm_field, .condition_select_field, .second_word, .issue_words,
  .issue_cycles, .unknown_op, .decode_busy);

`default_nettype wire

// File: odu_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// program fetch and condition unit model
// ----------------------------------------------------------------
module odu_fetch_model (
  // clock
  input  wire logic       mclk,
  // fetch words and condition result
  output var logic        fetch_valid,
  output var logic [15:0] fetch_word,
  output var logic        cond_done,
  output var logic        cond_taken
);
  logic [15:0] last_word;

  // quiet at time zero
  initial
  begin
    fetch_valid = 1'b0;
    fetch_word = 16'h0;
    cond_done = 1'b0;
    cond_taken = 1'b0;
    last_word = 16'h0;
  end

  // one word for one edge; the next one may follow at once
  task automatic put(input logic [15:0] w);
    @(posedge mclk);
    fetch_valid <= 1'b1;
    fetch_word <= w;
    cond_done <= 1'b0;
    last_word = w;
  endtask

  // released lines show inverted stale data, so nothing is read by luck
  task automatic stop();
    @(posedge mclk);
    fetch_valid <= 1'b0;
    fetch_word <= ~last_word;
    cond_done <= 1'b0;
    cond_taken <= ~cond_taken;
  endtask

  // condition outcome for one cycle
  task automatic resolve(input logic t);
    @(posedge mclk);
    fetch_valid <= 1'b0;
    fetch_word <= ~last_word;
    cond_done <= 1'b1;
    cond_taken <= t;
  endtask
endmodule

`default_nettype wire

// File: odu_pkg.sv
package odu_pkg;

  // ----------------------------------------------------------------
  // operation codes issued to execution
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    OP_NONE              = 7'h00,
    OP_MULT_ACCUM        = 7'h01,
    OP_MULT_ACCUM_MOVE   = 7'h02,
    OP_AUX_POINTER       = 7'h03,
    OP_AUX_MODIFY        = 7'h04,
    OP_MULTIPLY_OP       = 7'h05,
    OP_MULTIPLY_IMM      = 7'h06,
    OP_MULT_ADD_PREV     = 7'h07,
    OP_MULT_SUB_PREV     = 7'h08,
    OP_MULT_UNSIGNED     = 7'h09,
    OP_SQUARE_ADD        = 7'h0a,
    OP_SQUARE_SUB        = 7'h0b,
    OP_ACC_NEGATE        = 7'h0c,
    OP_ACC_FROM_PRODUCT  = 7'h0d,
    OP_ACC_MINUS_PRODUCT = 7'h0e,
    OP_ACC_SHIFT_LEFT    = 7'h0f,
    OP_ACC_SHIFT_RIGHT   = 7'h10,
    OP_ACC_ROTATE_LEFT   = 7'h11,
    OP_ACC_ROTATE_RIGHT  = 7'h12,
    OP_STACK_TO_ACC      = 7'h13,
    OP_ACC_TO_STACK      = 7'h14,
    OP_STACK_TO_MEMORY   = 7'h15,
    OP_MEMORY_TO_STACK   = 7'h16,
    OP_SUBROUTINE_RETURN = 7'h17,
    OP_COND_RETURN       = 7'h18,
    OP_REPEAT_MEM        = 7'h19,
    OP_REPEAT_IMM        = 7'h1a,
    OP_STORE_ACC_HIGH    = 7'h1b,
    OP_STORE_ACC_LOW     = 7'h1c,
    OP_STORE_AUX         = 7'h1d,
    OP_AUX_SUB_IMM       = 7'h1e,
    OP_SET_INTM          = 7'h1f,
    OP_SET_OVM           = 7'h20,
    OP_SET_BLOCK_PROG    = 7'h21,
    OP_SET_SXM           = 7'h22,
    OP_SET_TC            = 7'h23,
    OP_SET_EXT_FLAG      = 7'h24,
    OP_SET_CARRY         = 7'h25,
    OP_STORE_PROD_HIGH   = 7'h26,
    OP_STORE_PROD_LOW    = 7'h27,
    OP_PRODUCT_SHIFT     = 7'h28,
    OP_STORE_STATUS0     = 7'h29,
    OP_STORE_STATUS1     = 7'h2a,
    OP_STORE_LONG_IMM    = 7'h2b,
    OP_SUB_MEM_SHIFT     = 7'h2c,
    OP_SUB_LONG_IMM      = 7'h2d,
    OP_SUB_HIGH          = 7'h2e,
    OP_SUB_SHORT_IMM     = 7'h2f,
    OP_SUB_WITH_BORROW   = 7'h30,
    OP_COND_SUBTRACT     = 7'h31,
    OP_SUB_NO_SIGN_EXT   = 7'h32,
    OP_SUB_TEMP_SHIFT    = 7'h33,
    OP_OR_MEM            = 7'h34,
    OP_OR_LONG_IMM       = 7'h35,
    OP_OR_IMM_SHIFT16    = 7'h36,
    OP_XOR_MEM           = 7'h37,
    OP_XOR_LONG_IMM      = 7'h38,
    OP_XOR_IMM_SHIFT16   = 7'h39,
    OP_LOAD_HIGH_ROUND   = 7'h3a,
    OP_ACC_NORMALIZE     = 7'h3b
  } odu_op_t;

  // ----------------------------------------------------------------
  // decoder states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT2 = 3'b010,
    ST_COND  = 3'b100
  } odu_state_t;

  // ----------------------------------------------------------------
  // cycle counts and field layout
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_ONE      = 3'h1;
  localparam logic [2:0] CYC_TWO      = 3'h2;
  localparam logic [2:0] CYC_THREE    = 3'h3;
  localparam logic [2:0] CYC_FOUR     = 3'h4;
  localparam logic [1:0] WORDS_ONE    = 2'h1;
  localparam logic [1:0] WORDS_TWO    = 2'h2;
  localparam int         ADDR_MSB     = 7;
  localparam int         SEL_MSB      = 10;
  localparam logic [3:0] SHIFT_SIXTEEN = 4'h0;

endpackage

// File: odu_table.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// combinational opcode table for the first word
// ------------------------------------------------------------------
module odu_table (
  // opcode word
  input  wire logic [15:0]     word,
  // decoded result
  output odu_pkg::odu_op_t     op,
  output logic [1:0]           words,
  output logic [2:0]           cycles,
  output logic                 is_cond,
  output logic                 valid
);

  // one sum-of-cases lookup; unmatched codes belong to other decoders
  always_comb
  begin
    op      = odu_pkg::OP_NONE;
    words   = odu_pkg::WORDS_ONE;
    cycles  = odu_pkg::CYC_ONE;
    is_cond = 1'b0;
    casez (word)
      16'b1010_0010_????_????: begin op = odu_pkg::OP_MULT_ACCUM;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_THREE; end
      16'b1010_0011_????_????: begin op = odu_pkg::OP_MULT_ACCUM_MOVE;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_THREE; end
      16'b1000_1011_0000_0000: op = odu_pkg::OP_NONE;                   // no-op, not ours
      16'b1000_1011_1000_1???: op = odu_pkg::OP_AUX_POINTER;
      16'b1000_1011_????_????: op = odu_pkg::OP_AUX_MODIFY;
      16'b0101_0100_????_????: op = odu_pkg::OP_MULTIPLY_OP;
      16'b110?_????_????_????: op = odu_pkg::OP_MULTIPLY_IMM;
      16'b0101_0000_????_????: op = odu_pkg::OP_MULT_ADD_PREV;
      16'b0101_0001_????_????: op = odu_pkg::OP_MULT_SUB_PREV;
      16'b0101_0101_????_????: op = odu_pkg::OP_MULT_UNSIGNED;
      16'b0101_0010_????_????: op = odu_pkg::OP_SQUARE_ADD;
      16'b0101_0011_????_????: op = odu_pkg::OP_SQUARE_SUB;
      16'b1011_1110_0000_0010: op = odu_pkg::OP_ACC_NEGATE;
      16'b1011_1110_0000_0011: op = odu_pkg::OP_ACC_FROM_PRODUCT;
      16'b1011_1110_0000_0101: op = odu_pkg::OP_ACC_MINUS_PRODUCT;
      16'b1011_1110_0000_1001: op = odu_pkg::OP_ACC_SHIFT_LEFT;
      16'b1011_1110_0000_1010: op = odu_pkg::OP_ACC_SHIFT_RIGHT;
      16'b1011_1110_0000_1100: op = odu_pkg::OP_ACC_ROTATE_LEFT;
      16'b1011_1110_0000_1101: op = odu_pkg::OP_ACC_ROTATE_RIGHT;
      16'b1011_1110_0011_0010: op = odu_pkg::OP_STACK_TO_ACC;
      16'b1011_1110_0011_1100: op = odu_pkg::OP_ACC_TO_STACK;
      16'b1000_1010_????_????: op = odu_pkg::OP_STACK_TO_MEMORY;
      16'b0111_0110_????_????: op = odu_pkg::OP_MEMORY_TO_STACK;
      16'b1110_1111_0000_0000: begin op = odu_pkg::OP_SUBROUTINE_RETURN;
        cycles = odu_pkg::CYC_FOUR; end
      16'b1110_11??_????_????: begin op = odu_pkg::OP_COND_RETURN;
        cycles = odu_pkg::CYC_FOUR; is_cond = 1'b1; end
      16'b0000_1011_????_????: op = odu_pkg::OP_REPEAT_MEM;
      16'b1011_1011_????_????: op = odu_pkg::OP_REPEAT_IMM;
      16'b1001_1???_????_????: op = odu_pkg::OP_STORE_ACC_HIGH;
      16'b1001_0???_????_????: op = odu_pkg::OP_STORE_ACC_LOW;
      16'b1000_0???_????_????: op = odu_pkg::OP_STORE_AUX;
      16'b0111_1100_????_????: op = odu_pkg::OP_AUX_SUB_IMM;
      16'b1011_1110_0100_0001: op = odu_pkg::OP_SET_INTM;
      16'b1011_1110_0100_0011: op = odu_pkg::OP_SET_OVM;
      16'b1011_1110_0100_0101: op = odu_pkg::OP_SET_BLOCK_PROG;
      16'b1011_1110_0100_0111: op = odu_pkg::OP_SET_SXM;
      16'b1011_1110_0100_1011: op = odu_pkg::OP_SET_TC;
      16'b1011_1110_0100_1101: op = odu_pkg::OP_SET_EXT_FLAG;
      16'b1011_1110_0100_1111: op = odu_pkg::OP_SET_CARRY;
      16'b1000_1101_????_????: op = odu_pkg::OP_STORE_PROD_HIGH;
      16'b1000_1100_????_????: op = odu_pkg::OP_STORE_PROD_LOW;
      16'b1000_1110_????_????: op = odu_pkg::OP_STORE_STATUS0;
      16'b1000_1111_????_????: op = odu_pkg::OP_STORE_STATUS1;
      16'b1010_1110_????_????: begin op = odu_pkg::OP_STORE_LONG_IMM;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_TWO; end
      16'b0011_????_????_????: op = odu_pkg::OP_SUB_MEM_SHIFT;
      16'b1011_1111_1010_????: begin op = odu_pkg::OP_SUB_LONG_IMM;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_TWO; end
      16'b1011_1111_1100_????: begin op = odu_pkg::OP_OR_LONG_IMM;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_TWO; end
      16'b1011_1111_1101_????: begin op = odu_pkg::OP_XOR_LONG_IMM;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_TWO; end
      16'b1011_1111_0100_01??: op = odu_pkg::OP_NONE;                   // compare, not ours
      16'b1011_1111_1000_????: op = odu_pkg::OP_NONE;                   // load long, not ours
      16'b1011_1111_0000_1???: op = odu_pkg::OP_NONE;                   // aux long, not ours
      16'b1011_1111_????_????: op = odu_pkg::OP_PRODUCT_SHIFT;
      16'b0110_0101_????_????: op = odu_pkg::OP_SUB_HIGH;
      16'b1011_1010_????_????: op = odu_pkg::OP_SUB_SHORT_IMM;
      16'b0110_0100_????_????: op = odu_pkg::OP_SUB_WITH_BORROW;
      16'b0000_1010_????_????: op = odu_pkg::OP_COND_SUBTRACT;
      16'b0110_0110_????_????: op = odu_pkg::OP_SUB_NO_SIGN_EXT;
      16'b0110_0111_????_????: op = odu_pkg::OP_SUB_TEMP_SHIFT;
      16'b0110_1101_????_????: op = odu_pkg::OP_OR_MEM;
      16'b1011_1110_1000_0010: begin op = odu_pkg::OP_OR_IMM_SHIFT16;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_TWO; end
      16'b0110_1100_????_????: op = odu_pkg::OP_XOR_MEM;
      16'b1011_1110_1000_0011: begin op = odu_pkg::OP_XOR_IMM_SHIFT16;
        words = odu_pkg::WORDS_TWO; cycles = odu_pkg::CYC_TWO; end
      16'b0110_1000_????_????: op = odu_pkg::OP_LOAD_HIGH_ROUND;
      16'b1010_0000_????_????: op = odu_pkg::OP_ACC_NORMALIZE;
      default:                 op = odu_pkg::OP_NONE;
    endcase
    valid = (op != odu_pkg::OP_NONE);
  end

endmodule

`default_nettype wire
